// file: logic/rxd_dispatch.sv
/*
 * rxd_dispatch: receive transaction layer of a one-lane endpoint. Samples
 * checked TLPs from the link, classifies them by credit type, routes them
 * to configuration, CSR, DMA and message clients, and schedules completions.
 * Assumes the link drives pins stable around its rising edge, sends only
 * while link_rdy is high, and runs well below a quarter of the core clock.
 */
`timescale 1ns/100ps
module rxd_dispatch import rxd_pkg::*; #(
   parameter int BUF_DEPTH = 2,
   parameter logic [63:0] SERIAL_NUM = 64'h0123_4567_89ab_cdef // arbitrary
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // link side pins
   input wire logic link_clk,
   input wire logic link_vld,
   input wire rxd_tlp_t link_tlp,
   input wire logic link_up,
   input wire logic link_lcrc_err,
   input wire logic link_disp_err,
   output logic link_rdy,
   output logic link_nak,
   // nvm loader and configuration space
   input wire logic nvm_done,
   input wire logic nvm_mps_256,
   input wire logic [2:0] cfg_mps,
   // clients
   output logic [NUM_CLI-1:0] cli_vld,
   input wire logic [NUM_CLI-1:0] cli_rdy,
   output rxd_txn_t cli_txn,
   // completion scheduling
   output logic cpl_vld,
   input wire logic cpl_rdy,
   output rxd_cpl_t cpl_req,
   // events and credits
   output logic pm_nak_evt,
   output logic turn_off_evt,
   output logic err_vld,
   output rxd_sev_t err_sev,
   output logic [5:0] cred_ret,
   // power and identity
   input wire logic wake_evt,
   input wire logic in_d3cold,
   output logic wake_req,
   output logic [3:0] port_type,
   output logic [63:0] dev_serial
);

   initial begin
      if (BUF_DEPTH < 2) begin
         $error("rxd_dispatch: BUF_DEPTH below 2 cannot absorb a stall");
      end
   end

   // =========================================================
   // helpers
   // payload or request size in bytes from the dword length field
   function automatic logic [12:0] tlp_bytes(input logic [9:0] len);
      logic [12:0] dw;
      dw = (len == 10'h000) ? LEN_FULL_DW : {3'h0, len};
      return {dw[10:0], 2'h0};
   endfunction

   // effective payload limit: configured value capped by the nvm value
   function automatic logic [12:0] eff_limit(input logic [2:0] cfg,
                                             input logic [12:0] cap);
      return (cfg == CFG_MPS_128) ? MPS_SMALL : cap;
   endfunction

   // =========================================================
   // pin synchroniser and link edge finder
   rxd_pin_t pin_raw;
   rxd_pin_t s1_ff;       // first stage, read only by s2_ff
   rxd_pin_t s2_ff;       // second stage, safe to use
   logic lclk_d_ff;       // previous synchronised link clock
   logic lrise;           // link rising edge seen this cycle

   assign pin_raw = '{clk: link_clk, vld: link_vld, up: link_up,
                      lcrc_err: link_lcrc_err, disp_err: link_disp_err,
                      tlp: link_tlp};

   // two flip-flops on every pin; one lane, full duplex, no arbitration
   always_ff @(posedge clock) begin
      if (!resetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         lclk_d_ff <= 1'b0;
      end else begin
         s1_ff <= pin_raw;
         s2_ff <= s1_ff;
         lclk_d_ff <= s2_ff.clk;
      end
   end

   assign lrise = s2_ff.clk & ~lclk_d_ff;

   // =========================================================
   // payload cap and nvm state
   logic [12:0] cap_ff;   // supported payload from nvm
   logic nvm_ok_ff;       // nvm load finished
   logic [12:0] lim;

   // capture the nvm payload size once the load completes
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cap_ff <= MPS_SMALL;
         nvm_ok_ff <= 1'b0;
      end else if (nvm_done && !nvm_ok_ff) begin
         cap_ff <= nvm_mps_256 ? MPS_LARGE : MPS_SMALL;
         nvm_ok_ff <= 1'b1;
      end
   end

   assign lim = eff_limit(cfg_mps, cap_ff);

   // =========================================================
   // decode of the sampled TLP
   rxd_tlp_t t;
   rxd_disp_t d;
   logic is4;
   logic hasd;
   logic mal;             // malformed, dropped
   logic ur;              // unsupported request
   logic [12:0] nbytes;

   assign t = s2_ff.tlp;
   assign is4 = t.fmt[FMT_4DW_BIT];
   assign hasd = t.fmt[FMT_DATA_BIT];
   assign nbytes = tlp_bytes(t.len);

   // classify, pick credits, client and completion; the digest bit only
   // shifts nothing here since no digest is ever examined
   always_comb begin
      d = '0;
      mal = 1'b0;
      ur = 1'b0;
      d.txn.kind = K_NONE;
      d.txn.addr = t.addr;
      d.txn.len = t.len;
      d.txn.data = t.data;
      d.txn.code = t.code;
      d.txn.ro = t.attr[ATTR_RO_BIT];
      d.cpl.req_id = t.req_id;
      d.cpl.tag = t.tag;
      d.cpl.attr = t.attr;
      d.cpl.status = CPL_SC;
      d.dest = DST_CSR;
      if (t.typ == TYP_MEM) begin
         // long header must carry an address above 4 GB
         if (is4 && t.addr[63:32] == 32'h0000_0000) begin
            mal = 1'b1;
         end
         d.fwd = 1'b1;
         if (hasd) begin
            d.txn.kind = K_MWR;
            d.credit[CR_PH] = 1'b1;
            d.credit[CR_PD] = 1'b1;
            if (nbytes > lim) begin
               mal = 1'b1;
            end
         end else begin
            d.txn.kind = K_MRD;
            d.credit[CR_NPH] = 1'b1;
            d.need_cpl = 1'b1;
            d.cpl.with_data = 1'b1;
            if (nbytes > MAX_RD_BYTES) begin
               mal = 1'b1;
            end
         end
      end else if (t.typ == TYP_MEMLK) begin
         // locked read: answered unsupported, never forwarded
         ur = 1'b1;
         d.credit[CR_NPH] = 1'b1;
         d.need_cpl = 1'b1;
         d.cpl.status = CPL_UR;
      end else if (t.typ == TYP_IO || t.typ == TYP_CFG0) begin
         d.fwd = 1'b1;
         d.need_cpl = 1'b1;
         d.credit[CR_NPH] = 1'b1;
         d.credit[CR_NPD] = hasd;
         d.cpl.with_data = ~hasd;
         if (t.typ == TYP_IO) begin
            d.txn.kind = hasd ? K_IOWR : K_IORD;
         end else begin
            d.txn.kind = hasd ? K_CFGWR : K_CFGRD;
            d.dest = DST_CFG;
            // retry status until nvm has loaded
            if (!nvm_ok_ff) begin
               d.fwd = 1'b0;
               d.cpl.status = CPL_CRS;
               d.cpl.with_data = 1'b0;
            end
         end
      end else if (t.typ == TYP_CPL) begin
         d.txn.kind = K_CPL;
         d.dest = DST_DMA;
         d.fwd = 1'b1;
         d.credit[CR_CPLH] = 1'b1;
         d.credit[CR_CPLD] = hasd;
      end else if (t.typ == TYP_CPLLK) begin
         // locked completion: drop, consume credit
         ur = 1'b1;
         d.credit[CR_CPLH] = 1'b1;
         d.credit[CR_CPLD] = hasd;
      end else if (t.typ[4:3] == TYP_MSG_HI) begin
         d.txn.kind = K_MSG;
         d.dest = DST_MSG;
         d.credit[CR_PH] = 1'b1;
         d.credit[CR_PD] = hasd;
         d.fwd = 1'b1;
         if (t.code == MSG_VEND_T0) begin
            ur = 1'b1;
            d.fwd = 1'b0;
         end else if (t.code[7:4] == MSG_INDIC_HI || t.code == MSG_SLOT_PWR ||
                      t.code == MSG_VEND_T1 || t.code == MSG_UNLOCK) begin
            d.fwd = 1'b0; // silently dropped
         end
      end else begin
         mal = 1'b1;
      end
   end

   // =========================================================
   // buffer between decode and dispatch
   logic enq_vld;
   logic enq_rdy;
   rxd_disp_t h;          // head entry
   logic h_vld;
   logic pop;

   // accept only good TLPs on a link edge while trained and up
   assign enq_vld = lrise & s2_ff.vld & s2_ff.up & t.crc_ok & ~mal;

   rxd_fifo2 #(
      .WIDTH($bits(rxd_disp_t)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clock(clock),
      .resetn(resetn),
      .in_vld(enq_vld),
      .in_rdy(enq_rdy),
      .in_data(d),
      .out_vld(h_vld),
      .out_rdy(pop),
      .out_data(h)
   );

   // =========================================================
   // link status back to the far side
   logic rdy_ff;          // room to take the next TLP
   logic nak_ff;          // replay request for the last link edge

   // ready follows buffer room; nak holds for one link period
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdy_ff <= 1'b0;
         nak_ff <= 1'b0;
      end else begin
         rdy_ff <= enq_rdy & ~enq_vld;
         if (lrise) begin
            nak_ff <= s2_ff.lcrc_err;
         end
      end
   end

   assign link_rdy = rdy_ff;
   assign link_nak = nak_ff;

   // =========================================================
   // error reporting
   logic ev_ff;
   rxd_sev_t sev_ff;

   // one report per link edge; the most severe cause wins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ev_ff <= 1'b0;
         sev_ff <= SEV_COR;
      end else begin
         ev_ff <= 1'b0;
         if (lrise && s2_ff.vld && mal) begin
            ev_ff <= 1'b1;
            sev_ff <= SEV_FATAL;
         end else if (lrise && s2_ff.vld && t.crc_ok && ur) begin
            ev_ff <= 1'b1;
            sev_ff <= SEV_NONFATAL;
         end else if (lrise && (s2_ff.lcrc_err || s2_ff.disp_err ||
                                (s2_ff.vld && !t.crc_ok))) begin
            // symbol errors are only reported, no replay
            ev_ff <= 1'b1;
            sev_ff <= SEV_COR;
         end
      end
   end

   assign err_vld = ev_ff;
   assign err_sev = sev_ff;

   // =========================================================
   // dispatch to clients and completion scheduling
   logic cli_ok;
   logic cpl_ok;
   logic cplv_ff;
   rxd_cpl_t cpl_ff;

   // head waits for its client, and for a free completion slot
   assign cli_ok = ~h.fwd | cli_rdy[h.dest];
   assign cpl_ok = ~h.need_cpl | ~cplv_ff | cpl_rdy;
   assign pop = h_vld & cli_ok & cpl_ok;

   // one valid line per client, held until that client accepts
   always_comb begin
      cli_vld = '0;
      cli_vld[h.dest] = h_vld & h.fwd & cpl_ok;
   end

   assign cli_txn = h.txn;

   // completion slot, loaded as the request leaves the buffer
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cplv_ff <= 1'b0;
         cpl_ff <= '0;
      end else if (pop && h.need_cpl) begin
         cplv_ff <= 1'b1;
         cpl_ff <= h.cpl;
      end else if (cpl_rdy) begin
         cplv_ff <= 1'b0;
      end
   end

   assign cpl_vld = cplv_ff;
   assign cpl_req = cpl_ff;

   // =========================================================
   // credits and message side signals
   logic [5:0] cred_ff;
   logic asnak_ff;
   logic toff_ff;

   // credits and message pulses only once the entry has been taken
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cred_ff <= '0;
         asnak_ff <= 1'b0;
         toff_ff <= 1'b0;
      end else begin
         cred_ff <= pop ? h.credit : 6'h00;
         asnak_ff <= pop & (h.txn.kind == K_MSG) & (h.txn.code == MSG_ASPM_NAK);
         toff_ff <= pop & (h.txn.kind == K_MSG) & (h.txn.code == MSG_TURN_OFF);
      end
   end

   assign cred_ret = cred_ff;
   assign pm_nak_evt = asnak_ff;
   assign turn_off_evt = toff_ff;

   // =========================================================
   // wake, port type and serial number
   logic wake_ff;
   logic [3:0] ptype_ff;
   logic [63:0] serial_ff;

   // wake request holds from the event until D3cold is left
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wake_ff <= 1'b0;
         ptype_ff <= PORT_TYPE_NATIVE;
         serial_ff <= SERIAL_NUM;
      end else begin
         if (!in_d3cold) begin
            wake_ff <= 1'b0;
         end else if (wake_evt) begin
            wake_ff <= 1'b1;
         end
         ptype_ff <= PORT_TYPE_NATIVE;
         serial_ff <= SERIAL_NUM;
      end
   end

   assign wake_req = wake_ff;
   assign port_type = ptype_ff;
   assign dev_serial = serial_ff;

endmodule

// file: include/rxd_pkg.sv
/*
 * rxd_pkg: constants, encodings and carrier structs shared by the receive
 * transaction dispatcher, its property checker, link model and test bench.
 * Assumes a link layer that hands over one whole checked TLP per link edge.
 */
package rxd_pkg;

   // =========================================================
   // header format and type encodings
   localparam logic [4:0] TYP_MEM = 5'h00;     // memory request
   localparam logic [4:0] TYP_MEMLK = 5'h01;   // locked memory read
   localparam logic [4:0] TYP_IO = 5'h02;      // i/o request
   localparam logic [4:0] TYP_CFG0 = 5'h04;    // type 0 configuration
   localparam logic [4:0] TYP_CPL = 5'h0a;     // completion
   localparam logic [4:0] TYP_CPLLK = 5'h0b;   // locked completion
   localparam logic [1:0] TYP_MSG_HI = 2'h2;   // type[4:3] of a message
   localparam int FMT_4DW_BIT = 0;             // fmt bit: four-dword header
   localparam int FMT_DATA_BIT = 1;            // fmt bit: payload present
   localparam int ATTR_RO_BIT = 1;             // attr bit: relaxed ordering

   // =========================================================
   // message codes
   localparam logic [7:0] MSG_ASPM_NAK = 8'h14;
   localparam logic [7:0] MSG_TURN_OFF = 8'h19;
   localparam logic [7:0] MSG_SLOT_PWR = 8'h50;
   localparam logic [7:0] MSG_VEND_T0 = 8'h7e;
   localparam logic [7:0] MSG_VEND_T1 = 8'h7f;
   localparam logic [7:0] MSG_UNLOCK = 8'h00;
   localparam logic [3:0] MSG_INDIC_HI = 4'h4; // indicator codes 0x4x

   // =========================================================
   // completion status, sizes, credits, identity
   localparam logic [2:0] CPL_SC = 3'h0;       // successful
   localparam logic [2:0] CPL_UR = 3'h1;       // unsupported request
   localparam logic [2:0] CPL_CRS = 3'h2;      // configuration retry
   localparam logic [12:0] MPS_SMALL = 13'h0080; // 128 byte payload
   localparam logic [12:0] MPS_LARGE = 13'h0100; // 256 byte payload
   localparam logic [12:0] MAX_RD_BYTES = 13'h1000; // 4 KB read request
   localparam logic [12:0] LEN_FULL_DW = 13'h0400; // length 0 means 1024
   localparam logic [2:0] CFG_MPS_128 = 3'h0;  // config encoding of 128
   localparam int CR_PH = 0;
   localparam int CR_PD = 1;
   localparam int CR_NPH = 2;
   localparam int CR_NPD = 3;
   localparam int CR_CPLH = 4;
   localparam int CR_CPLD = 5;
   localparam logic [3:0] PORT_TYPE_NATIVE = 4'h0; // native endpoint
   localparam int NUM_CLI = 4;

   // =========================================================
   // enumerations
   typedef enum logic [1:0] {
      DST_CFG = 2'b00,
      DST_CSR = 2'b01,
      DST_DMA = 2'b10,
      DST_MSG = 2'b11
   } rxd_dest_t;

   typedef enum logic [3:0] {
      K_MRD = 4'b0000,
      K_MWR = 4'b0001,
      K_IORD = 4'b0010,
      K_IOWR = 4'b0011,
      K_CFGRD = 4'b0100,
      K_CFGWR = 4'b0101,
      K_CPL = 4'b0110,
      K_MSG = 4'b0111,
      K_NONE = 4'b1000
   } rxd_kind_t;

   typedef enum logic [1:0] {
      SEV_COR = 2'b00,
      SEV_NONFATAL = 2'b01,
      SEV_FATAL = 2'b10
   } rxd_sev_t;

   // =========================================================
   // carriers
   typedef struct packed {
      logic [1:0] fmt;
      logic [4:0] typ;
      logic [1:0] attr;
      logic td;
      logic [9:0] len;
      logic [15:0] req_id;
      logic [7:0] tag;
      logic [63:0] addr;
      logic [7:0] code;
      logic [31:0] data;
      logic crc_ok;
   } rxd_tlp_t;

   typedef struct packed {
      logic clk;
      logic vld;
      logic up;
      logic lcrc_err;
      logic disp_err;
      rxd_tlp_t tlp;
   } rxd_pin_t;

   typedef struct packed {
      rxd_kind_t kind;
      logic [63:0] addr;
      logic [9:0] len;
      logic [31:0] data;
      logic [7:0] code;
      logic ro;
   } rxd_txn_t;

   typedef struct packed {
      logic [15:0] req_id;
      logic [7:0] tag;
      logic [1:0] attr;
      logic [2:0] status;
      logic with_data;
   } rxd_cpl_t;

   typedef struct packed {
      rxd_txn_t txn;
      rxd_cpl_t cpl;
      logic fwd;
      rxd_dest_t dest;
      logic need_cpl;
      logic [5:0] credit;
   } rxd_disp_t;

endpackage

// file: logic/rxd_fifo2.sv
/*
 * rxd_fifo2: small valid/ready buffer between decode and dispatch.
 * Assumes one clock; the writer honours in_rdy, the reader may stall.
 */
`timescale 1ns/100ps
module rxd_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // filling side
   input wire logic in_vld,
   output logic in_rdy,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_vld,
   input wire logic out_rdy,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // =========================================================
   // storage and pointers
   logic [WIDTH-1:0] mem_ff [DEPTH];   // entry array
   logic [PW-1:0] wr_ff;               // write slot
   logic [PW-1:0] rd_ff;               // read slot
   logic [PW:0] cnt_ff;                // entries held
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("rxd_fifo2: DEPTH must be a power of two, at least 2");
      end
   end

   // honest full and empty
   assign in_rdy = (cnt_ff != (PW+1)'(DEPTH));
   assign out_vld = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
   assign push = in_vld & in_rdy;
   assign pop = out_vld & out_rdy;

   // write into the free slot
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   // pointer and fill count upkeep
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wr_ff + PW'(1);
         end
         if (pop) begin
            rd_ff <= rd_ff + PW'(1);
         end
         cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule

// file: verif/rxd_dispatch_props.sv
/*
 * rxd_dispatch_props: checks on client, completion and power ports.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
module rxd_dispatch_props import rxd_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // client handoff
   input wire logic [NUM_CLI-1:0] cli_vld,
   input wire logic [NUM_CLI-1:0] cli_rdy,
   input wire rxd_txn_t cli_txn,
   // completion and credits
   input wire logic cpl_vld,
   input wire logic cpl_rdy,
   input wire rxd_cpl_t cpl_req,
   input wire logic [5:0] cred_ret,
   // power and identity
   input wire logic wake_evt,
   input wire logic in_d3cold,
   input wire logic wake_req,
   input wire logic [3:0] port_type
);
   // =========================================================
   // handshake steps
   default clocking dc @(posedge clock); endclocking
   default disable iff (!resetn);
   // a client takes the head entry
   sequence acc_s;
      |(cli_vld & cli_rdy);
   endsequence
   // reads answered with data
   sequence rd_s;
      cli_txn.kind inside {K_MRD, K_IORD, K_CFGRD};
   endsequence
   // non-posted writes answered without data
   sequence wr_s;
      cli_txn.kind inside {K_CFGWR, K_IOWR};
   endsequence
   // =========================================================
   // checks
   port_native_a: assert property (port_type == PORT_TYPE_NATIVE)
      else $error("bad port type");
   one_client_a: assert property ($onehot0(cli_vld))
      else $error("two clients");
   head_hold_a: assert property (|(cli_vld & ~cli_rdy) |=> $stable(cli_vld) && $stable(cli_txn))
      else $error("head dropped");
   cred_after_a: assert property (acc_s |=> cred_ret != 6'h00)
      else $error("no credit");
   posted_cred_a: assert property (acc_s ##0 cli_txn.kind == K_MWR |-> cli_vld[DST_CSR] ##1 cred_ret == 6'h03)
      else $error("bad write");
   read_cpl_a: assert property (acc_s ##0 rd_s |=> cpl_vld && cpl_req.with_data && cred_ret == 6'h04)
      else $error("bad read cpl");
   npwr_cpl_a: assert property (acc_s ##0 wr_s |=> cpl_vld && !cpl_req.with_data && cred_ret == 6'h0c)
      else $error("bad write cpl");
   cpl_dma_a: assert property (acc_s ##0 cli_txn.kind == K_CPL |-> cli_vld[DST_DMA] ##1 cred_ret == 6'h30)
      else $error("bad cpl");
   cpl_hold_a: assert property (cpl_vld && !cpl_rdy |=> cpl_vld && $stable(cpl_req))
      else $error("cpl lost");
   wake_set_a: assert property (wake_evt && in_d3cold |=> wake_req)
      else $error("no wake");
   wake_clr_a: assert property (!in_d3cold |=> !wake_req)
      else $error("stale wake");
endmodule
bind rxd_dispatch rxd_dispatch_props chk_u (.*);

// file: verif/rxd_link_model.sv
/*
 * rxd_link_model: upstream port sending whole TLPs.
 * Assumes core clock pacing; link clock runs only in frames.
 */
`timescale 1ns/100ps
module rxd_link_model import rxd_pkg::*; (
   // pacing clock and flow control
   input wire logic clock,
   input wire logic link_rdy,
   // link pins
   output logic link_clk,
   output logic link_vld,
   output rxd_tlp_t link_tlp
);
   // =========================================================
   // idle pins: link clock parked low
   initial begin
      link_clk = 1'b0;
      link_vld = 1'b0;
      link_tlp = '0;
   end
   // one frame of 320 ns: wait for room, present, clock, release
   task automatic send(input rxd_tlp_t t);
      int n = 0;
      while (link_rdy !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      link_vld <= 1'b1;
      link_tlp <= t;
      repeat (4) @(posedge clock);
      link_clk <= 1'b1;
      repeat (4) @(posedge clock);
      link_clk <= 1'b0;
      link_vld <= 1'b0;
      // released data shows the inverse
      link_tlp <= ~t;
   endtask
endmodule

// file: verif/rxd_dispatch_test.sv
/*
 * rxd_dispatch_test: directed bench for the receive dispatcher.
 * Assumes the link model and bound checker.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module rxd_dispatch_test import rxd_pkg::*; ();
   // =========================================================
   // design ports and captured results
   logic clock, resetn, link_clk, link_vld, link_up, link_lcrc_err, link_disp_err, link_rdy, link_nak;
   logic nvm_done, nvm_mps_256, cpl_vld, cpl_rdy, pm_nak_evt, turn_off_evt, err_vld, wake_evt, in_d3cold, wake_req;
   logic [2:0] cfg_mps;
   logic [NUM_CLI-1:0] cli_vld, cli_rdy, g_dst;
   logic [5:0] cred_ret, g_cr;
   logic [3:0] port_type;
   logic [63:0] dev_serial;
   logic [1:0] g_ev;
   logic g_ro, g_nak, g_err;
   rxd_tlp_t link_tlp;
   rxd_txn_t cli_txn;
   rxd_cpl_t cpl_req, g_cpl;
   rxd_sev_t err_sev, g_sev;
   int miscompares = 0, checked = 0, cyc = 0, n_acc = 0, n_cpl = 0;
   rxd_dispatch dut_u (.*);
   rxd_link_model lnk_u (.clock, .link_rdy, .link_clk, .link_vld, .link_tlp);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // collect what the dispatcher hands out
   always @(posedge clock) begin
      if (|(cli_vld & cli_rdy)) begin
         g_dst = g_dst | cli_vld;
         g_ro = cli_txn.ro;
         n_acc++;
      end
      if (cpl_vld && cpl_rdy) begin
         g_cpl = cpl_req;
         n_cpl++;
      end
      g_cr = g_cr | cred_ret;
      g_nak = g_nak | link_nak;
      g_ev = g_ev | {pm_nak_evt, turn_off_evt};
      if (err_vld) begin
         g_err = 1'b1;
         g_sev = err_sev;
      end
   end
   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   // =========================================================
   // helpers
   function automatic rxd_tlp_t mk(logic [1:0] f, logic [4:0] y, logic [63:0] a, logic [9:0] l = 10'h001,
                                   logic [7:0] c = 8'h00, logic k = 1'b1);
      mk = '{f, y, 2'h2, 1'b0, l, 16'h00a5, 8'h3c, a, c, 32'h0, k};
   endfunction
   // send one TLP and let it settle
   task automatic go(input rxd_tlp_t t);
      @(posedge clock);
      {g_dst, g_ro, g_cr, g_nak, g_ev, g_err} = '0;
      n_acc = 0;
      n_cpl = 0;
      lnk_u.send(t);
      repeat (16) @(posedge clock);
   endtask
   // client, credits and {completion, with data}
   task automatic one(input rxd_tlp_t t, input logic [3:0] d, input logic [5:0] c, input logic [1:0] p);
      go(t);
      `CHK(g_dst, d)
      `CHK(g_cr, c)
      `CHK({n_cpl == 1, g_cpl.with_data & (n_cpl == 1)}, p)
   endtask
   // =========================================================
   // scenarios
   task automatic t_reset;
      @(negedge clock);
      `CHK({port_type, link_rdy, cli_vld, dev_serial}, {PORT_TYPE_NATIVE, 1'b1, 4'h0, 64'h0123_4567_89ab_cdef})
   endtask
   // config before nvm load, completion stalled
   task automatic t_crs;
      cpl_rdy <= 1'b0;
      go(mk(2'h0, TYP_CFG0, 64'h10));
      cpl_rdy <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK({g_dst, n_cpl == 1, g_cpl.status, g_cpl.with_data}, {4'h0, 1'b1, CPL_CRS, 1'b0})
      nvm_done <= 1'b1;
   endtask
   task automatic t_kinds;
      one(mk(2'h0, TYP_MEM, 64'h1000, 10'h0), 4'h2, 6'h04, 2'h3);
      `CHK({g_cpl.req_id, g_cpl.tag, g_cpl.attr, g_cpl.status}, {16'h00a5, 8'h3c, 2'h2, CPL_SC})
      one(mk(2'h0, TYP_IO, 64'h10), 4'h2, 6'h04, 2'h3);
      one(mk(2'h0, TYP_CFG0, 64'h10), 4'h1, 6'h04, 2'h3);
      one(mk(2'h3, TYP_MEM, 64'h1_0000_0000), 4'h2, 6'h03, 2'h0);
      `CHK(g_ro, 1'b1)
      one(mk(2'h2, TYP_IO, 64'h10), 4'h2, 6'h0c, 2'h2);
      one(mk(2'h2, TYP_CFG0, 64'h10), 4'h1, 6'h0c, 2'h2);
      one(mk(2'h2, TYP_CPL, '0), 4'h4, 6'h30, 2'h0);
      one(mk(2'h1, 5'h14, '0, 10'h0, 8'h20), 4'h8, 6'h01, 2'h0);
      one(mk(2'h0, TYP_MEMLK, 64'h1000), 4'h0, 6'h04, 2'h2);
      `CHK({g_err, g_sev, g_cpl.status}, {1'b1, SEV_NONFATAL, CPL_UR})
   endtask
   task automatic t_msgs;
      go(mk(2'h1, 5'h13, '0, 10'h0, MSG_TURN_OFF));
      `CHK({g_ev, g_cr}, {2'h1, 6'h01})
      go(mk(2'h1, 5'h14, '0, 10'h0, MSG_ASPM_NAK));
      `CHK({g_ev, g_cr}, {2'h2, 6'h01})
      go(mk(2'h1, 5'h14, '0, 10'h0, 8'h41));
      `CHK({g_dst, g_err, g_cr}, {4'h0, 1'b0, 6'h01})
      go(mk(2'h1, 5'h14, '0, 10'h0, MSG_VEND_T0));
      `CHK({g_err, g_sev}, {1'b1, SEV_NONFATAL})
   endtask
   // a bad read and bad writes, then a raised payload cap
   task automatic t_drop;
      one(mk(2'h1, TYP_MEM, 64'h1000), 4'h0, 6'h00, 2'h0);
      `CHK({g_err, g_sev}, {1'b1, SEV_FATAL})
      one(mk(2'h2, TYP_MEM, 64'h1000, 10'h001, 8'h00, 1'b0), 4'h0, 6'h00, 2'h0);
      one(mk(2'h2, TYP_MEM, 64'h1000, 10'h040), 4'h0, 6'h00, 2'h0);
      cfg_mps <= 3'h1;
      one(mk(2'h2, TYP_MEM, 64'h1000, 10'h040), 4'h2, 6'h03, 2'h0);
   endtask
   // symbol error first: no stale replay
   task automatic t_link;
      link_disp_err <= 1'b1;
      go(mk(2'h2, TYP_MEM, 64'h1000));
      `CHK(g_nak, 1'b0)
      link_disp_err <= 1'b0;
      link_lcrc_err <= 1'b1;
      go(mk(2'h2, TYP_MEM, 64'h1000));
      `CHK(g_nak, 1'b1)
      link_lcrc_err <= 1'b0;
   endtask
   // fill while client stalls, then drain
   task automatic t_stall;
      cli_rdy <= 4'h0;
      go(mk(2'h2, TYP_MEM, 64'h2000));
      lnk_u.send(mk(2'h2, TYP_MEM, 64'h3000));
      repeat (8) @(negedge clock);
      `CHK({link_rdy, cli_vld, g_cr}, {1'b0, 4'h2, 6'h00})
      @(posedge clock);
      cli_rdy <= 4'hf;
      repeat (8) @(posedge clock);
      `CHK({n_acc == 2, g_cr}, {1'b1, 6'h03})
   endtask
   task automatic t_wake;
      @(posedge clock);
      in_d3cold <= 1'b1;
      wake_evt <= 1'b1;
      @(posedge clock);
      wake_evt <= 1'b0;
      @(negedge clock);
      `CHK(wake_req, 1'b1)
      @(posedge clock);
      in_d3cold <= 1'b0;
      repeat (2) @(negedge clock);
      `CHK(wake_req, 1'b0)
   endtask
   // =========================================================
   // verdict and main sequence
   task automatic print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      {resetn, link_up, link_lcrc_err, link_disp_err, nvm_done, wake_evt, in_d3cold} = '0;
      nvm_mps_256 = 1'b1;
      cfg_mps = 3'h0;
      cli_rdy = 4'hf;
      cpl_rdy = 1'b1;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      link_up <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_crs();
      t_kinds();
      t_msgs();
      t_drop();
      t_link();
      t_stall();
      t_wake();
      print_verdict();
   end
endmodule
